/* slgwi_core.sv */
// Top of the lamp, pin and wake indicator block
// Behaviour
// RULE1 - Wake event asserts the wake output when the wake function is enabled.
// RULE2 - Software picks wake output polarity and push-pull or open-drain drive.
// RULE3 - Wake event and wake output never end the power-saving state.
// RULE4 - Power-saving state ends only on chip select with write strobe.
// RULE5 - Host aims its wake write at the byte-order test register.
// RULE6 - Each of three pins is push-pull out, open-drain out or input.
// RULE7 - Each pin selects its own function or a status lamp.
// RULE8 - Lamp-assigned pins are open-drain, pulling low only.
// RULE9 - Speed lamp low at 100M, negotiating or unplugged; high at 10M.
// RULE10 - Link and activity lamp held low while link is valid.
// RULE11 - Activity flashes lamp high 80 ms, then low at least 80 ms.
// RULE12 - Duplex lamp low in full duplex, high otherwise.
module slgwi_core
    import slgwi_pkg::*;
#(
    parameter int ACT_TICKS = slgwi_pkg::ACT_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [slgwi_pkg::ADDR_W-1:0] regAddr,
    input wire logic [slgwi_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [slgwi_pkg::DATA_W-1:0] regRdata,
    input wire logic chipSelectN,
    input wire logic writeStrobeN,
    input wire logic linkUp,
    input wire logic speed10,
    input wire logic autoNegBusy,
    input wire logic fullDuplex,
    input wire logic linkActivity,
    input wire logic wakeEvent,
    input wire logic [slgwi_pkg::NUM_GP-1:0] gpPinIn,
    output logic [slgwi_pkg::NUM_GP-1:0] gpPinOut,
    output logic [slgwi_pkg::NUM_GP-1:0] gpPinOe,
    output logic wakeIndicatorOut,
    output logic wakeIndicatorOe,
    output logic powerSaving,
    output logic irq
);
    import slgwi_pkg::*;

    if (ACT_TICKS < 1) begin : gBadTicks
        $error("ACT_TICKS must be at least one");
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [NUM_GP-1:0] gpDir_q;
    logic [NUM_GP-1:0] gpOd_q;
    logic [NUM_GP-1:0] gpLamp_q;
    logic [NUM_GP-1:0] gpOut_q;
    logic wakeEn_q;
    logic wakePol_q;
    logic wakeOd_q;
    logic wakeLatch_q;
    logic [IRQ_W-1:0] intSts_q;
    logic [IRQ_W-1:0] intSts_d;
    logic [IRQ_W-1:0] intMask_q;
    logic sleep_q;
    logic [DATA_W-1:0] rdata_q;
    logic irq_q;
    logic wakeOut_q;
    logic wakeOe_q;
    logic [NUM_GP-1:0] gpInPrev_q;

    // ************************************************************
    // Pin synchronisers for the asynchronous inputs
    // ************************************************************
    logic [6:0] asyncIn;
    logic [6:0] syncA_q;
    logic [6:0] syncB_q;
    assign asyncIn = {wakeEvent, linkActivity, fullDuplex, autoNegBusy,
                      speed10, linkUp, 1'b0};

    logic csSyncA_q;
    logic csSyncB_q;
    logic wrSyncA_q;
    logic wrSyncB_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            syncA_q <= '0;
            syncB_q <= '0;
            csSyncA_q <= 1'b1;
            csSyncB_q <= 1'b1;
            wrSyncA_q <= 1'b1;
            wrSyncB_q <= 1'b1;
        end else begin
            syncA_q <= asyncIn;
            syncB_q <= syncA_q;
            csSyncA_q <= chipSelectN;
            csSyncB_q <= csSyncA_q;
            wrSyncA_q <= writeStrobeN;
            wrSyncB_q <= wrSyncA_q;
        end
    end

    logic sLink;
    logic sSpeed10;
    logic sAneg;
    logic sFull;
    logic sAct;
    logic sWake;
    assign sLink = syncB_q[1];
    assign sSpeed10 = syncB_q[2];
    assign sAneg = syncB_q[3];
    assign sFull = syncB_q[4];
    assign sAct = syncB_q[5];
    assign sWake = syncB_q[6];

    // ************************************************************
    // Address decode
    // ************************************************************
    logic wrCfg;
    logic wrOut;
    logic wrWake;
    logic wrSts;
    logic wrMask;
    logic wrPwr;
    assign wrCfg = regWr && (regAddr == REG_GP_CFG);
    assign wrOut = regWr && (regAddr == REG_GP_OUT);
    assign wrWake = regWr && (regAddr == REG_WAKE_CFG);
    assign wrSts = regWr && (regAddr == REG_INT_STS);
    assign wrMask = regWr && (regAddr == REG_INT_MASK);
    assign wrPwr = regWr && (regAddr == REG_PWR_CTL);

    // Host write cycle on the pins: both strobes low
    logic hostWrite;
    assign hostWrite = !csSyncB_q && !wrSyncB_q; // RULE4

    // ************************************************************
    // Lamp generation
    // ************************************************************
    logic speedLampN;
    logic duplexLampN;
    logic linkActLampN;
    // Negotiating or unplugged reads as the fast setting
    assign speedLampN = sSpeed10 && sLink && !sAneg; // RULE9
    assign duplexLampN = !(sLink && sFull); // RULE12

    slgwi_act_state_t actState_q;
    slgwi_act_state_t actState_d;
    logic [$clog2(ACT_TICKS+1)-1:0] actCnt_q;
    logic actDone;
    assign actDone = (actCnt_q == '0);

    always_comb begin
        actState_d = actState_q;
        unique case (actState_q)
            ACT_IDLE: begin
                if (sLink && sAct) begin
                    actState_d = ACT_OFF;
                end
            end
            ACT_OFF: begin
                if (actDone) begin
                    actState_d = ACT_ON;
                end
            end
            ACT_ON: begin
                // Minimum low time before another flash
                if (actDone) begin
                    actState_d = ACT_IDLE;
                end
            end
            default: actState_d = ACT_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            actState_q <= ACT_IDLE;
            actCnt_q <= '0;
        end else begin
            actState_q <= actState_d; // RULE11
            if (actState_d != actState_q && actState_d != ACT_IDLE) begin
                actCnt_q <= ($clog2(ACT_TICKS+1))'(ACT_TICKS - 1);
            end else if (!actDone) begin
                actCnt_q <= actCnt_q - 1'b1;
            end
        end
    end

    // Lamp is on solid for a link, dark during the flash phase
    assign linkActLampN = !sLink || (actState_q == ACT_OFF); // RULE10

    // ************************************************************
    // Per-pin drivers
    // ************************************************************
    logic [NUM_GP-1:0] lampLevels;
    logic [NUM_GP-1:0] gpInLevel;
    assign lampLevels = {duplexLampN, linkActLampN, speedLampN};

    slgwi_pin_if pinBus [NUM_GP] ();

    for (genvar g = 0; g < NUM_GP; g++) begin : gPin
        assign pinBus[g].useLamp = gpLamp_q[g]; // RULE7
        assign pinBus[g].lampLevel = lampLevels[g];
        assign pinBus[g].isOutput = gpDir_q[g]; // RULE6
        assign pinBus[g].openDrain = gpOd_q[g];
        assign pinBus[g].outLevel = gpOut_q[g];
        assign pinBus[g].pinIn = gpPinIn[g];
        assign gpPinOut[g] = pinBus[g].pinOut;
        assign gpPinOe[g] = pinBus[g].pinOe;
        assign gpInLevel[g] = pinBus[g].inLevel;
        slgwi_pin_drv uDrv (
            .mclk(mclk),
            .rst(rst),
            .p(pinBus[g])
        );
    end

    // ************************************************************
    // Wake indicator and power state
    // ************************************************************
    logic wakeSet;
    logic resumeEvt;
    logic [NUM_GP-1:0] gpRise;
    assign wakeSet = sWake && wakeEn_q; // RULE1
    assign resumeEvt = sleep_q && hostWrite;
    assign gpRise = gpInLevel & ~gpInPrev_q & ~gpDir_q & ~gpLamp_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sleep_q <= 1'b0;
        end else if (resumeEvt) begin
            // Wake event deliberately absent here
            sleep_q <= 1'b0; // RULE3 RULE4
        end else if (wrPwr && regWdata[PWR_SLEEP_BIT]) begin
            // Software only enters; leaving needs the host pins
            sleep_q <= 1'b1; // RULE4
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wakeLatch_q <= 1'b0;
        end else if (wakeSet) begin
            wakeLatch_q <= 1'b1; // RULE1
        end else if (wrWake && regWdata[WAKE_EVT_BIT]) begin
            wakeLatch_q <= 1'b0;
        end
    end

    logic wakeLvl;
    assign wakeLvl = wakeLatch_q ~^ wakePol_q;
    // Open-drain form never drives high; the pull-up gives the high level
    always_ff @(posedge mclk) begin
        if (rst) begin
            wakeOut_q <= 1'b0;
            wakeOe_q <= 1'b1;
        end else begin
            wakeOut_q <= !wakeOd_q && wakeLvl; // RULE2
            wakeOe_q <= wakeOd_q && wakeLvl; // RULE2
        end
    end

    // ************************************************************
    // Configuration writes
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            gpDir_q <= '0;
            gpOd_q <= '0;
            gpLamp_q <= '0;
            gpOut_q <= '0;
            wakeEn_q <= 1'b0;
            wakePol_q <= 1'b0;
            wakeOd_q <= 1'b0;
            intMask_q <= '0;
            gpInPrev_q <= '1;
        end else begin
            gpInPrev_q <= gpInLevel;
            if (wrCfg) begin
                gpDir_q <= regWdata[CFG_DIR_LSB +: NUM_GP];
                gpOd_q <= regWdata[CFG_OD_LSB +: NUM_GP];
                gpLamp_q <= regWdata[CFG_LAMP_LSB +: NUM_GP];
            end
            if (wrOut) begin
                gpOut_q <= regWdata[NUM_GP-1:0];
            end
            if (wrWake) begin
                wakeEn_q <= regWdata[WAKE_EN_BIT];
                wakePol_q <= regWdata[WAKE_POL_BIT];
                wakeOd_q <= regWdata[WAKE_OD_BIT];
            end
            if (wrMask) begin
                intMask_q <= regWdata[IRQ_W-1:0];
            end
        end
    end

    // ************************************************************
    // Interrupt status: set wins over write-one-to-clear
    // ************************************************************
    logic [IRQ_W-1:0] intSet;
    assign intSet = {gpRise, resumeEvt, wakeSet};
    always_comb begin
        intSts_d = intSts_q;
        if (wrSts) begin
            intSts_d = intSts_q & ~regWdata[IRQ_W-1:0];
        end
        intSts_d = intSts_d | intSet;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            intSts_q <= '0;
            irq_q <= 1'b0;
        end else begin
            intSts_q <= intSts_d;
            irq_q <= |(intSts_d & intMask_q);
        end
    end

    // ************************************************************
    // Read data, valid the cycle after the strobe only
    // ************************************************************
    logic [DATA_W-1:0] rdMux;
    logic [DATA_W-1:0] cfgWord;
    logic [DATA_W-1:0] wakeWord;
    always_comb begin
        cfgWord = '0;
        cfgWord[CFG_DIR_LSB +: NUM_GP] = gpDir_q;
        cfgWord[CFG_OD_LSB +: NUM_GP] = gpOd_q;
        cfgWord[CFG_LAMP_LSB +: NUM_GP] = gpLamp_q;
        wakeWord = '0;
        wakeWord[WAKE_EN_BIT] = wakeEn_q;
        wakeWord[WAKE_POL_BIT] = wakePol_q;
        wakeWord[WAKE_OD_BIT] = wakeOd_q;
        wakeWord[WAKE_EVT_BIT] = wakeLatch_q;
        unique case (regAddr)
            REG_GP_CFG: rdMux = cfgWord;
            REG_GP_OUT: rdMux = {{(DATA_W-NUM_GP){1'b0}}, gpOut_q};
            REG_GP_IN: rdMux = {{(DATA_W-NUM_GP){1'b0}}, gpInLevel};
            REG_WAKE_CFG: rdMux = wakeWord;
            REG_INT_STS: rdMux = {{(DATA_W-IRQ_W){1'b0}}, intSts_q};
            REG_INT_MASK: rdMux = {{(DATA_W-IRQ_W){1'b0}}, intMask_q};
            REG_BYTE_TEST: rdMux = BYTE_TEST_VAL;
            REG_PWR_CTL: rdMux = {{(DATA_W-1){1'b0}}, sleep_q};
            default: rdMux = '0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (regRd) begin
            rdata_q <= rdMux;
        end else begin
            rdata_q <= '0;
        end
    end

    assign regRdata = rdata_q;
    assign wakeIndicatorOut = wakeOut_q;
    assign wakeIndicatorOe = wakeOe_q;
    assign powerSaving = sleep_q;
    assign irq = irq_q;
endmodule : slgwi_core

/* slgwi_core_monitor.sv */
// Port-level assertions for the lamp, pin and wake block
module slgwi_core_monitor
    import slgwi_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [slgwi_pkg::ADDR_W-1:0] regAddr,
    input wire logic [slgwi_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [slgwi_pkg::DATA_W-1:0] regRdata,
    input wire logic chipSelectN,
    input wire logic writeStrobeN,
    input wire logic linkUp,
    input wire logic speed10,
    input wire logic autoNegBusy,
    input wire logic fullDuplex,
    input wire logic linkActivity,
    input wire logic wakeEvent,
    input wire logic [slgwi_pkg::NUM_GP-1:0] gpPinIn,
    input wire logic [slgwi_pkg::NUM_GP-1:0] gpPinOut,
    input wire logic [slgwi_pkg::NUM_GP-1:0] gpPinOe,
    input wire logic wakeIndicatorOut,
    input wire logic wakeIndicatorOe,
    input wire logic powerSaving,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // Checks
    // ********
    wire logic hostWr = !chipSelectN && !writeStrobeN;
    wire logic sleepWr = regWr && regAddr == REG_PWR_CTL
        && regWdata[PWR_SLEEP_BIT];
    wire logic maskOff = regWr && regAddr == REG_INT_MASK
        && regWdata == '0;
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);

    property p_rdIdle;
        !$past(regRd) |-> regRdata == '0;
    endproperty
    a_rdIdle: assert property (p_rdIdle)
        else $error("read data not zero outside read slot");
    property p_byteTest;
        $past(regRd) && $past(regAddr) == REG_BYTE_TEST
            |-> regRdata == BYTE_TEST_VAL;
    endproperty
    a_byteTest: assert property (p_byteTest)
        else $error("byte test register read wrong");
    property p_wakeCause;
        $fell(powerSaving) |-> $past(hostWr, 2);
    endproperty
    a_wakeCause: assert property (p_wakeCause)
        else $error("left power saving without host write");
    property p_wakeBound;
        hostWr [*5] |-> !powerSaving;
    endproperty
    a_wakeBound: assert property (p_wakeBound)
        else $error("host write did not end power saving");
    property p_psHold;
        (powerSaving && !hostWr) [*3] |=> powerSaving;
    endproperty
    a_psHold: assert property (p_psHold)
        else $error("power saving ended with no host write");
    property p_sleepEnter;
        sleepWr |-> ##[1:2] powerSaving;
    endproperty
    a_sleepEnter: assert property (p_sleepEnter)
        else $error("sleep write did not enter power saving");
    property p_sleepCause;
        $rose(powerSaving) |-> $past(sleepWr) || $past(sleepWr, 2);
    endproperty
    a_sleepCause: assert property (p_sleepCause)
        else $error("power saving entered without sleep write");
    property p_irqOff;
        maskOff |-> ##2 !irq;
    endproperty
    a_irqOff: assert property (p_irqOff)
        else $error("interrupt high with all sources masked");

    c_wakeByPins: cover property ($fell(powerSaving));
    c_irq: cover property ($rose(irq));
    c_sleepEvent: cover property (powerSaving && wakeEvent);
endmodule : slgwi_core_monitor

bind slgwi_core slgwi_core_monitor slgwi_core_monitor_inst (.*);

/* slgwi_partner.sv */
// Pads with pull-ups, external pin drive and host wake strobes
module slgwi_partner
    import slgwi_pkg::*;
(
    input wire logic mclk,
    input wire logic [slgwi_pkg::NUM_GP-1:0] gpPinOut,
    input wire logic [slgwi_pkg::NUM_GP-1:0] gpPinOe,
    input wire logic [slgwi_pkg::NUM_GP-1:0] extDrv,
    input wire logic [slgwi_pkg::NUM_GP-1:0] extEn,
    input wire logic wakeIndicatorOut,
    input wire logic wakeIndicatorOe,
    input wire logic hostReq,
    output logic [slgwi_pkg::NUM_GP-1:0] gpPinIn,
    output logic wakeLevel,
    output logic chipSelectN,
    output logic writeStrobeN
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] holdCnt = 4'h0;
    // Released pads float to the pull-up
    assign gpPinIn = (~gpPinOe & gpPinOut) | (gpPinOe & ~extEn)
        | (gpPinOe & extEn & extDrv);
    assign wakeLevel = wakeIndicatorOe ? 1'b1 : wakeIndicatorOut;
    // Host holds both strobes low together for six cycles
    always @(posedge mclk) begin
        if (hostReq) begin
            holdCnt <= 4'h6;
        end else if (holdCnt != 4'h0) begin
            holdCnt <= holdCnt - 4'h1;
        end
    end
    assign chipSelectN = holdCnt == 4'h0;
    assign writeStrobeN = holdCnt == 4'h0;
endmodule : slgwi_partner

/* slgwi_pin_drv.sv */
// One pin: synchroniser, mode selection and registered pad drive
module slgwi_pin_drv (
    input wire logic mclk,
    input wire logic rst,
    slgwi_pin_if.pin p
);
    logic syncA_q;
    logic syncB_q;
    logic pinOut_q;
    logic pinOe_q;
    logic wantLow;
    logic driveHigh;

    // Lamp function only ever pulls low
    assign wantLow = p.useLamp ? !p.lampLevel
                   : (p.isOutput && !p.outLevel); // RULE8
    assign driveHigh = !p.useLamp && p.isOutput && !p.openDrain
                     && p.outLevel; // RULE6

    always_ff @(posedge mclk) begin
        if (rst) begin
            // Idle pad sits at the pull-up, so no false edge after reset
            syncA_q <= 1'b1;
            syncB_q <= 1'b1;
            pinOut_q <= 1'b0;
            pinOe_q <= 1'b1;
        end else begin
            syncA_q <= p.pinIn;
            syncB_q <= syncA_q;
            pinOut_q <= driveHigh;
            pinOe_q <= !(wantLow || driveHigh);
        end
    end

    assign p.pinOut = pinOut_q;
    assign p.pinOe = pinOe_q;
    assign p.inLevel = syncB_q;
endmodule : slgwi_pin_drv

/* slgwi_pin_if.sv */
// Carrier between a pin driver and the core for one configurable pin
interface slgwi_pin_if;
    logic useLamp;
    logic lampLevel;
    logic isOutput;
    logic openDrain;
    logic outLevel;
    logic pinIn;
    logic pinOut;
    logic pinOe;
    logic inLevel;

    modport core (
        output useLamp,
        output lampLevel,
        output isOutput,
        output openDrain,
        output outLevel,
        input inLevel
    );
    modport pin (
        input useLamp,
        input lampLevel,
        input isOutput,
        input openDrain,
        input outLevel,
        input pinIn,
        output pinOut,
        output pinOe,
        output inLevel
    );
endinterface : slgwi_pin_if

/* slgwi_pkg.sv */
// Constants, register map and field layout of the lamp, pin and wake block
package slgwi_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_GP = 3;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] REG_GP_CFG = 8'h00;
    localparam logic [7:0] REG_GP_OUT = 8'h04;
    localparam logic [7:0] REG_GP_IN = 8'h08;
    localparam logic [7:0] REG_WAKE_CFG = 8'h0C;
    localparam logic [7:0] REG_INT_STS = 8'h10;
    localparam logic [7:0] REG_INT_MASK = 8'h14;
    localparam logic [7:0] REG_BYTE_TEST = 8'h18;
    localparam logic [7:0] REG_PWR_CTL = 8'h1C;

    localparam logic [31:0] BYTE_TEST_VAL = 32'h8765_4321;

    // ************************************************************
    // Field layout of the pin configuration register
    // ************************************************************
    localparam int CFG_DIR_LSB = 0;
    localparam int CFG_OD_LSB = 4;
    localparam int CFG_LAMP_LSB = 8;

    // Wake configuration fields
    localparam int WAKE_EN_BIT = 0;
    localparam int WAKE_POL_BIT = 1;
    localparam int WAKE_OD_BIT = 2;
    localparam int WAKE_EVT_BIT = 3;

    // Interrupt status bits
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_RESUME_BIT = 1;
    localparam int IRQ_GPIN_LSB = 2;
    localparam int IRQ_W = 5;

    // Power control: bit 0 enters the power-saving state
    localparam int PWR_SLEEP_BIT = 0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int ACT_MS = 80;
    localparam int ACT_CYCLES = CLK_HZ / 1000 * ACT_MS;

    typedef enum logic [2:0] {
        ACT_IDLE = 3'b001,
        ACT_OFF = 3'b010,
        ACT_ON = 3'b100
    } slgwi_act_state_t;
endpackage : slgwi_pkg

/* status_led_gpio_wake_indicator_tb_top.sv */
// Self-checking bench for the lamp, pin and wake block
module status_led_gpio_wake_indicator_tb_top
    import slgwi_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICKS = 20;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic linkUp = 0, speed10 = 0, autoNegBusy = 0, fullDuplex = 0;
    logic linkActivity = 0, wakeEvent = 0, hostReq = 0;
    logic [NUM_GP-1:0] extDrv = '0, extEn = '0, rv, gpPinIn;
    logic [NUM_GP-1:0] gpPinOut, gpPinOe;
    logic [DATA_W-1:0] regRdata, rdv;
    logic wakeIndicatorOut, wakeIndicatorOe, powerSaving, irq;
    logic wakeLevel, chipSelectN, writeStrobeN, pol, od;
    int miscompares = 0, samplesChecked = 0, cycles = 0;
    int i, k, n, hi, lo;
    int expRst[$] = '{0, 0, 7, 0, 0, 0, BYTE_TEST_VAL, 0};

    slgwi_core #(.ACT_TICKS(TICKS)) slgwi_core_inst (.mclk(mclk),
        .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN),
        .linkUp(linkUp), .speed10(speed10), .autoNegBusy(autoNegBusy),
        .fullDuplex(fullDuplex), .linkActivity(linkActivity),
        .wakeEvent(wakeEvent), .gpPinIn(gpPinIn), .gpPinOut(gpPinOut),
        .gpPinOe(gpPinOe), .wakeIndicatorOut(wakeIndicatorOut),
        .wakeIndicatorOe(wakeIndicatorOe), .powerSaving(powerSaving),
        .irq(irq));
    slgwi_partner slgwi_partner_inst (.mclk(mclk), .gpPinOut(gpPinOut),
        .gpPinOe(gpPinOe), .extDrv(extDrv), .extEn(extEn),
        .wakeIndicatorOut(wakeIndicatorOut),
        .wakeIndicatorOe(wakeIndicatorOe), .hostReq(hostReq),
        .gpPinIn(gpPinIn), .wakeLevel(wakeLevel),
        .chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN));

    initial begin
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(posedge mclk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        rdv = regRdata;
        chk(rdv, e);
    endtask : rdChk
    task automatic results;
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    initial begin
        void'($urandom(32'hce4a_fcdd));
        tick(4);
        rst <= 1'b0;
        for (i = 0; i < 8; i++) rdChk(8'(i * 4), expRst[i]);
        wr(8'h20, 32'hffff_ffff);
        rdChk(8'h20, 32'h0000_0000);
        wr(REG_BYTE_TEST, 32'h0000_0000);
        rdChk(REG_BYTE_TEST, BYTE_TEST_VAL);
        $display("test registers done");
        // Modes: input, push-pull output, open-drain output
        for (k = 0; k < 3; k++) begin
            rv = 3'($urandom);
            wr(REG_GP_CFG, k == 0 ? 32'h0 : (k == 1 ? 32'h7 : 32'h77));
            wr(REG_GP_OUT, {29'h0, rv});
            extEn <= (k == 0) ? 3'b111 : 3'b000;
            extDrv <= ~rv;
            tick(6);
            #1;
            chk(gpPinIn, k == 0 ? 3'(~rv) : rv);
            chk(gpPinOe, k == 0 ? 3'b111 : (k == 1 ? 3'b000 : rv));
            rdChk(REG_GP_IN, {29'h0, k == 0 ? ~rv : rv});
        end
        extEn <= 3'b000;
        $display("test pins done");
        wr(REG_GP_CFG, 32'h0000_0700);
        for (k = 0; k < 16; k++) begin
            {linkUp, speed10, autoNegBusy, fullDuplex} <= 4'(k);
            tick(8);
            #1;
            chk(gpPinIn[0], k[3] & k[2] & !k[1]);
            chk(gpPinIn[1], !k[3]);
            chk(gpPinIn[2], !(k[3] & k[0]));
            chk(3'(gpPinOe | ~gpPinOut), 3'b111);
            tick(1);
        end
        {linkUp, speed10, autoNegBusy, fullDuplex} <= 4'h8;
        linkActivity <= 1'b1;
        n = 0;
        hi = 0;
        lo = 0;
        // Bounded waits so a stuck lamp cannot hang the run
        while (gpPinIn[1] !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        while (gpPinIn[1] === 1'b1 && hi < 100) begin
            tick(1);
            hi++;
        end
        while (gpPinIn[1] !== 1'b1 && lo < 100) begin
            tick(1);
            lo++;
        end
        chk(hi, TICKS);
        chk(lo >= TICKS && lo < 100, 1);
        linkActivity <= 1'b0;
        tick(2 * TICKS + 10);
        #1;
        chk(gpPinIn[1], 1'b0);
        $display("test lamps done");
        wr(REG_INT_STS, 32'h0000_001f);
        for (k = 0; k < 5; k++) begin
            pol = k[0];
            od = k[1];
            wr(REG_WAKE_CFG, {28'h0, 1'b1, od, pol, k < 4});
            wr(REG_INT_MASK, 32'h0000_0001);
            tick(3);
            #1;
            chk(wakeLevel, !pol);
            chk(irq, 1'b0);
            tick(1);
            wakeEvent <= 1'b1;
            tick(4);
            wakeEvent <= 1'b0;
            tick(6);
            #1;
            chk(wakeLevel, k < 4 ? pol : 1'b1);
            chk(od & !wakeIndicatorOe & wakeIndicatorOut, 1'b0);
            if (k < 4) begin
                chk(irq, 1'b1);
                wr(REG_INT_MASK, 32'h0000_0000);
                tick(2);
                #1;
                chk(irq, 1'b0);
                wr(REG_INT_MASK, 32'h0000_0001);
                wr(REG_INT_STS, 32'h0000_0001);
                tick(2);
                #1;
                chk(irq, 1'b0);
            end
        end
        $display("test wake pin done");
        wr(REG_WAKE_CFG, 32'h0000_000b);
        wr(REG_PWR_CTL, 32'h0000_0001);
        tick(3);
        #1;
        chk(powerSaving, 1'b1);
        tick(1);
        wakeEvent <= 1'b1;
        tick(4);
        wakeEvent <= 1'b0;
        tick(12);
        #1;
        chk(powerSaving, 1'b1);
        chk(wakeLevel, 1'b1);
        tick(1);
        hostReq <= 1'b1;
        tick(1);
        hostReq <= 1'b0;
        wr(REG_BYTE_TEST, $urandom);
        tick(8);
        #1;
        chk(powerSaving, 1'b0);
        rdChk(REG_INT_STS, 32'h0000_0003);
        $display("test power saving done");
        results();
    end
endmodule : status_led_gpio_wake_indicator_tb_top
